// >>> shared/dbgfd_pkg.sv
// package for the debug feature discovery block: map, fields, capabilities
// assumes a 32-bit word bus with byte addresses in a 4 KB window
package dbgfd_pkg;

  // ********************************************************************
  // register map (byte addresses)
  // ********************************************************************
  localparam logic [11:0] ROM_BASE_OFS     = 12'h000;
  localparam logic [11:0] ROM_LAST_OFS     = 12'h01C;
  localparam logic [11:0] HALT_CTRL_OFS    = 12'h100;
  localparam logic [11:0] EXC_MON_OFS      = 12'h104;
  localparam logic [11:0] WATCH_CTRL_OFS   = 12'h108;
  localparam logic [11:0] BKPT_CTRL_OFS    = 12'h10C;
  localparam logic [11:0] BKPT_REMAP_OFS   = 12'h110;
  localparam logic [11:0] LEVEL_OFS        = 12'h114;
  localparam logic [11:0] STIM_BASE_OFS    = 12'h200;
  localparam logic [11:0] STIM_LAST_OFS    = 12'h21C;

  // ********************************************************************
  // field positions and reset values
  // ********************************************************************
  localparam int HALT_EN_BIT      = 0;
  localparam int HALT_REQ_BIT     = 1;
  localparam int HALTED_BIT       = 17;
  localparam int MON_EN_BIT       = 16;
  localparam int MON_STEP_BIT     = 18;
  localparam int TRACE_EN_BIT     = 24;
  localparam int NUMCMP_LSB       = 28;
  localparam int NO_TRC_PKT_BIT   = 27;
  localparam int NO_EXT_TRIG_BIT  = 26;
  localparam int NO_CYC_BIT       = 25;
  localparam int NO_PRF_BIT       = 24;
  localparam int NUM_CODE_LSB     = 4;
  localparam int LIT_CNT_LSB      = 8;
  localparam int REMAP_SUP_BIT    = 29;
  localparam int REMAP_ADDR_LSB   = 5;
  localparam int REMAP_ADDR_W     = 24;
  localparam logic [23:0] REMAP_RESET = 24'h000000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [3:0]  FULL_WORD   = 4'hF;

  // ********************************************************************
  // table entries; bit 0 is the presence bit
  // ********************************************************************
  localparam logic [31:0] ROM_SYS_ENTRY    = 32'hFFF0F003;
  localparam logic [31:0] ROM_WATCH_BASE   = 32'hFFF02002;
  localparam logic [31:0] ROM_BKPT_BASE    = 32'hFFF03002;
  localparam logic [31:0] ROM_STIM_BASE    = 32'hFFF01002;
  localparam logic [31:0] ROM_PORT_BASE    = 32'hFFF41002;
  localparam logic [31:0] ROM_ITRACE_BASE  = 32'hFFF42002;
  localparam logic [31:0] ROM_END_ENTRY    = 32'h00000000;

  typedef enum logic [1:0] {
    LVL_MINIMUM       = 2'h0,
    LVL_BASIC         = 2'h1,
    LVL_COMPREHENSIVE = 2'h2
  } dbgfd_level_t;

  typedef enum logic {
    DAP_JTAG     = 1'b0,
    DAP_TWO_WIRE = 1'b1
  } dbgfd_dap_t;

  typedef struct packed {
    logic       watch;
    logic       stim;
    logic       bkpt;
    logic       data_trace;
    logic       cyc;
    logic       prf;
    logic       remap;
    logic       halting;
    logic [3:0] n_watch;
    logic [3:0] n_code;
    logic [3:0] n_lit;
  } dbgfd_caps_t;

  function automatic dbgfd_caps_t dbgfd_caps_for(dbgfd_level_t lvl);
    dbgfd_caps_t c;
    c = '0;
    unique case (lvl)
      LVL_BASIC: begin
        c.watch   = 1'b1;
        c.bkpt    = 1'b1;
        c.halting = 1'b1;
        c.n_watch = 4'h1;
        c.n_code  = 4'h2;
      end
      LVL_COMPREHENSIVE: begin
        c = '1;
        c.n_watch = 4'h1;
        c.n_code  = 4'h2;
        c.n_lit   = 4'h0;
      end
      default: c = '0;
    endcase
    return c;
  endfunction : dbgfd_caps_for

endpackage : dbgfd_pkg

// >>> shared/dbgfd_rom_if.sv
// carrier between the main block and its table memory
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface dbgfd_rom_if;
  logic        rd_en;
  logic [2:0]  index;
  logic [3:0]  present;
  logic [31:0] rdata;
  modport host (output rd_en, output index, output present, input rdata);
  modport mem  (input rd_en, input index, input present, output rdata);
endinterface : dbgfd_rom_if

// >>> hw/dbgfd_rom.sv
// table of debug unit entries with registered read data
// assumes present bits are static configuration from the main block
`timescale 1ns/1ns
module dbgfd_rom (
  input  wire logic   clk_in,
  input  wire logic   reset_in,
  dbgfd_rom_if.mem    rom
);
  import dbgfd_pkg::*;

  logic [31:0] rdata_reg;

  function automatic logic [31:0] dbgfd_entry(input logic [2:0] idx,
                                               input logic [3:0] pres);
    unique case (idx)
      3'h0:    return ROM_SYS_ENTRY;
      3'h1:    return ROM_WATCH_BASE | {31'h0, pres[0]};
      3'h2:    return ROM_BKPT_BASE | {31'h0, pres[1]};
      3'h3:    return ROM_STIM_BASE | {31'h0, pres[2]};
      3'h4:    return ROM_PORT_BASE;
      3'h5:    return ROM_ITRACE_BASE | {31'h0, pres[3]};
      default: return ROM_END_ENTRY;
    endcase
  endfunction : dbgfd_entry

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_reg <= ROM_END_ENTRY;
    end else if (rom.rd_en) begin
      rdata_reg <= dbgfd_entry(rom.index, rom.present);
    end
  end

  assign rom.rdata = rdata_reg;

endmodule : dbgfd_rom

// >>> hw/dbgfd_top.sv
// debug feature discovery and enable logic with an Avalon-MM slave
// assumes core event inputs on REF_CLK_IN; the request pin is asynchronous
//
// What this block does
// - table entry bit 0 is set only for units that are built
// - no-trace-packet flag set exactly when data trace absent
// - no-external-trigger flag set when no comparator match outputs exist
// - cycle and profiling counter absence flags read one when missing
// - watch control reports the number of watch comparators
// - remap register bit 29 reads zero when only breakpoints exist
// - breakpoint control reports code and literal comparator counts
// - trace enable reads zero and ignores writes when no trace units
// - a monitor event with the monitor disabled becomes a hard fault
// - stimulus port writes always complete without a bus error
// - an instruction trace unit forces comparator match outputs
// - minimum level gives monitor stepping and request pin monitor entry
// - basic level: two breakpoints, one plain watchpoint, no stimulus unit
// - comprehensive: eight stimulus ports, full watch, remapping breakpoints
// - the access port is built on jtag or two-wire debug port
// - halt enable plus halt request halts; halted status follows the core
// - monitor exceptions only while halting is disabled
// - an all-zero table entry marks the end of the table
//
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
module dbgfd_top #(
  parameter dbgfd_pkg::dbgfd_level_t DEBUG_LEVEL    =
    dbgfd_pkg::LVL_COMPREHENSIVE,
  parameter dbgfd_pkg::dbgfd_dap_t   DAP_KIND       = dbgfd_pkg::DAP_JTAG,
  parameter bit                      ITRACE_PRESENT = 1'b0
) (
  input  wire logic        REF_CLK_IN,
  input  wire logic        RESET_IN,
  input  wire logic [11:0] AVS_ADDRESS_IN,
  input  wire logic        AVS_READ_IN,
  input  wire logic        AVS_WRITE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  input  wire logic [3:0]  AVS_BYTEENABLE_IN,
  output logic      [31:0] AVS_READDATA_OUT,
  output logic             AVS_WAITREQUEST_OUT,
  output logic      [1:0]  AVS_RESPONSE_OUT,
  input  wire logic        EXT_DEBUG_REQUEST_IN,
  input  wire logic        DEBUG_EVENT_IN,
  input  wire logic        CORE_HALTED_IN,
  input  wire logic        WATCH_MATCH_IN,
  output logic             HALT_REQUEST_OUT,
  output logic             MON_EXCEPTION_OUT,
  output logic             HARD_FAULT_OUT,
  output logic             MON_STEP_OUT,
  output logic             COMPARATOR_MATCH_OUT,
  output logic             STIM_VALID_OUT,
  output logic      [2:0]  STIM_PORT_OUT,
  output logic      [31:0] STIM_DATA_OUT
);
  import dbgfd_pkg::*;

  // ********************************************************************
  // configuration
  // ********************************************************************
  // level capability sets
  localparam dbgfd_caps_t CAPS = dbgfd_caps_for(DEBUG_LEVEL);
  localparam logic MATCH_SUP = ITRACE_PRESENT;
  localparam logic TRACE_UNITS = CAPS.watch | CAPS.stim;

  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b00,
    BUS_ANSWER = 2'b01
  } dbgfd_bus_t;

  typedef struct packed {
    dbgfd_bus_t  bus;
    logic        rom_sel;
    logic [31:0] rdata;
    logic [1:0]  resp;
    logic        halt_en;
    logic        halt_req;
    logic        halted;
    logic        mon_en;
    logic        mon_step;
    logic        trace_en;
    logic [23:0] remap_addr;
    logic        req_sync1;
    logic        req_sync2;
    logic        req_prev;
    logic        mon_exc;
    logic        hard_fault;
    logic        stim_valid;
    logic [2:0]  stim_port;
    logic [31:0] stim_data;
  } dbgfd_state_t;

  dbgfd_state_t st_reg;
  dbgfd_state_t st_next;
  dbgfd_rom_if  rom_bus ();

  function automatic logic in_range(input logic [11:0] a,
                                    input logic [11:0] lo,
                                    input logic [11:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_range

  // ********************************************************************
  // read data of the discovery registers
  // ********************************************************************
  logic [31:0] watch_word;
  logic [31:0] bkpt_word;
  logic [31:0] remap_word;
  logic [31:0] reg_word;
  logic        reg_hit;
  logic        event_now;
  logic        access;

  always_comb begin
    watch_word = '0;
    watch_word[NUMCMP_LSB +: 4]  = CAPS.n_watch;
    watch_word[NO_TRC_PKT_BIT]  = ~CAPS.data_trace;
    watch_word[NO_EXT_TRIG_BIT] = ~MATCH_SUP;
    watch_word[NO_CYC_BIT]      = ~CAPS.cyc;
    watch_word[NO_PRF_BIT]      = ~CAPS.prf;
    // watch unit registers are only visible with trace enabled
    if (!(CAPS.watch && st_reg.trace_en)) begin
      watch_word = '0;
    end
    bkpt_word = '0;
    bkpt_word[NUM_CODE_LSB +: 4] = CAPS.bkpt ? CAPS.n_code : 4'h0;
    bkpt_word[LIT_CNT_LSB +: 4]  = CAPS.bkpt ? CAPS.n_lit : 4'h0;
    remap_word = '0;
    remap_word[REMAP_SUP_BIT] = CAPS.bkpt & CAPS.remap;
    remap_word[REMAP_ADDR_LSB +: REMAP_ADDR_W] = st_reg.remap_addr;
  end

  always_comb begin
    reg_word = '0;
    reg_hit  = 1'b1;
    unique case (AVS_ADDRESS_IN)
      HALT_CTRL_OFS: begin
        reg_word[HALT_EN_BIT]  = st_reg.halt_en;
        reg_word[HALT_REQ_BIT] = st_reg.halt_req;
        reg_word[HALTED_BIT]   = st_reg.halted;
      end
      EXC_MON_OFS: begin
        reg_word[MON_EN_BIT]   = st_reg.mon_en;
        reg_word[MON_STEP_BIT] = st_reg.mon_step;
        reg_word[TRACE_EN_BIT] = st_reg.trace_en;
      end
      WATCH_CTRL_OFS: reg_word = watch_word;
      BKPT_CTRL_OFS:  reg_word = bkpt_word;
      BKPT_REMAP_OFS: reg_word = remap_word;
      LEVEL_OFS:      reg_word = {29'h0, DAP_KIND, DEBUG_LEVEL};
      default: begin
        // stimulus ports read as zero, never fault
        reg_hit = in_range(AVS_ADDRESS_IN, STIM_BASE_OFS, STIM_LAST_OFS);
      end
    endcase
  end

  // ********************************************************************
  // next state
  // ********************************************************************
  always_comb begin
    st_next    = st_reg;
    access     = AVS_READ_IN | AVS_WRITE_IN;
    event_now  = DEBUG_EVENT_IN | (st_reg.req_sync2 & ~st_reg.req_prev);
    st_next.req_sync1 = EXT_DEBUG_REQUEST_IN;
    st_next.req_sync2 = st_reg.req_sync1;
    st_next.req_prev  = st_reg.req_sync2;
    st_next.halted    = CORE_HALTED_IN;
    st_next.mon_exc    = 1'b0;
    st_next.hard_fault = 1'b0;
    st_next.stim_valid = 1'b0;

    unique case (st_reg.bus)
      BUS_IDLE: begin
        if (access) begin
          st_next.bus     = BUS_ANSWER;
          st_next.rom_sel = in_range(AVS_ADDRESS_IN, ROM_BASE_OFS,
                                     ROM_LAST_OFS);
          st_next.rdata   = reg_word;
          st_next.resp    = (reg_hit || st_next.rom_sel) ? RESP_OKAY
                                                         : RESP_SLVERR;
        end
      end
      BUS_ANSWER: begin
        st_next.bus = BUS_IDLE;
        // partial-word writes are dropped but still answered
        if (AVS_WRITE_IN && AVS_BYTEENABLE_IN == FULL_WORD) begin
          unique case (AVS_ADDRESS_IN)
            HALT_CTRL_OFS: begin
              st_next.halt_en  = CAPS.halting &
                                 AVS_WRITEDATA_IN[HALT_EN_BIT];
              st_next.halt_req = CAPS.halting &
                                 AVS_WRITEDATA_IN[HALT_REQ_BIT];
            end
            EXC_MON_OFS: begin
              st_next.mon_en   = AVS_WRITEDATA_IN[MON_EN_BIT];
              st_next.mon_step = AVS_WRITEDATA_IN[MON_STEP_BIT];
              // no trace units: bit not stored
              st_next.trace_en = TRACE_UNITS &
                                 AVS_WRITEDATA_IN[TRACE_EN_BIT];
            end
            BKPT_REMAP_OFS: begin
              if (CAPS.bkpt && CAPS.remap) begin
                st_next.remap_addr =
                  AVS_WRITEDATA_IN[REMAP_ADDR_LSB +: REMAP_ADDR_W];
              end
            end
            default: begin
              // stimulus write emitted only when the unit runs
              if (in_range(AVS_ADDRESS_IN, STIM_BASE_OFS, STIM_LAST_OFS)) begin
                st_next.stim_valid = CAPS.stim & st_reg.trace_en;
                st_next.stim_port  = AVS_ADDRESS_IN[4:2];
                st_next.stim_data  = AVS_WRITEDATA_IN;
              end
            end
          endcase
        end
      end
      default: st_next.bus = BUS_IDLE;
    endcase

    // events come after writes so a set beats a same-cycle clear
    if (event_now) begin
      if (st_reg.halt_en) begin
        st_next.halt_req = 1'b1;
      end else if (st_reg.mon_en) begin
        // monitor entry from the request pin or events
        st_next.mon_exc = 1'b1;
      end else begin
        st_next.hard_fault = 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      st_reg <= '{bus: BUS_IDLE, resp: RESP_OKAY, remap_addr: REMAP_RESET,
                  default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ********************************************************************
  // table memory and outputs
  // ********************************************************************
  // presence bits from the configuration
  assign rom_bus.present = {ITRACE_PRESENT, CAPS.stim, CAPS.bkpt,
                            CAPS.watch};
  assign rom_bus.rd_en   = (st_reg.bus == BUS_IDLE) & AVS_READ_IN;
  assign rom_bus.index   = AVS_ADDRESS_IN[4:2];

  dbgfd_rom u_rom (
    .clk_in   (REF_CLK_IN),
    .reset_in (RESET_IN),
    .rom      (rom_bus.mem)
  );

  assign AVS_WAITREQUEST_OUT  = access & (st_reg.bus == BUS_IDLE);
  assign AVS_READDATA_OUT     = st_reg.rom_sel ? rom_bus.rdata : st_reg.rdata;
  assign AVS_RESPONSE_OUT     = st_reg.resp;
  assign HALT_REQUEST_OUT     = st_reg.halt_en & st_reg.halt_req;
  assign MON_EXCEPTION_OUT    = st_reg.mon_exc;
  assign HARD_FAULT_OUT       = st_reg.hard_fault;
  assign MON_STEP_OUT         = st_reg.mon_step & st_reg.mon_en &
                                ~st_reg.halt_en;
  assign COMPARATOR_MATCH_OUT = MATCH_SUP & CAPS.watch & WATCH_MATCH_IN;
  assign STIM_VALID_OUT       = st_reg.stim_valid;
  assign STIM_PORT_OUT        = st_reg.stim_port;
  assign STIM_DATA_OUT        = st_reg.stim_data;

  // ********************************************************************
  // assertions
  // ********************************************************************
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RESET_IN);

  sequence req_s;
    (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT;
  endsequence
  sequence ans_s;
    !AVS_WAITREQUEST_OUT;
  endsequence

  bus_answer_a: assert property (req_s |=> ans_s)
    else $error("request not answered in one cycle");
  stim_ok_a: assert property (req_s and in_range(AVS_ADDRESS_IN,
      STIM_BASE_OFS, STIM_LAST_OFS) |=> AVS_RESPONSE_OUT == RESP_OKAY)
    else $error("stimulus access faulted");
  halt_pref_a: assert property (event_now && st_reg.halt_en |=>
      HALT_REQUEST_OUT && !MON_EXCEPTION_OUT && !HARD_FAULT_OUT)
    else $error("halting did not override monitor");
  escalate_a: assert property (event_now && !st_reg.halt_en &&
      !st_reg.mon_en |=> HARD_FAULT_OUT && !MON_EXCEPTION_OUT)
    else $error("disabled monitor did not escalate");
  mon_entry_a: assert property ($rose(EXT_DEBUG_REQUEST_IN) &&
      !st_reg.halt_en && st_reg.mon_en ##1 (!st_reg.halt_en &&
      st_reg.mon_en)[*2] |=> MON_EXCEPTION_OUT)
    else $error("request pin gave no monitor entry");
  halted_st_a: assert property (CORE_HALTED_IN |=> st_reg.halted)
    else $error("halted status not following core");
  trace_none_a: assert property (!TRACE_UNITS |-> !st_reg.trace_en)
    else $error("trace enable stored without trace units");
  flags_a: assert property (st_reg.trace_en && CAPS.watch |->
      watch_word[NO_TRC_PKT_BIT] == !CAPS.data_trace &&
      watch_word[NO_EXT_TRIG_BIT] == !MATCH_SUP)
    else $error("watch capability flags wrong");
  match_a: assert property (ITRACE_PRESENT && CAPS.watch &&
      WATCH_MATCH_IN |-> COMPARATOR_MATCH_OUT)
    else $error("match output missing with trace unit");
  rom_end_a: assert property (req_s and AVS_READ_IN &&
      AVS_ADDRESS_IN[4:2] == 3'h6 && st_next.rom_sel |=>
      AVS_READDATA_OUT == ROM_END_ENTRY)
    else $error("table end marker not zero");

endmodule : dbgfd_top

// >>> dv/dbgfd_host.sv
// debugger model: Avalon-MM master with caller-set byte enables in front of the debug block
// assumes the slave holds waitrequest high until it answers
`timescale 1ns/1ns
module dbgfd_host (
  input  wire logic        clk_in,
  input  wire logic        waitrequest_in,
  output logic      [11:0] address_out,
  output logic             read_out,
  output logic             write_out,
  output logic      [31:0] writedata_out,
  output logic      [3:0]  byteenable_out
);
  import dbgfd_pkg::*;
  logic hung;

  initial begin
    hung           = 1'b0;
    address_out    = 12'h000;
    read_out       = 1'b0;
    write_out      = 1'b0;
    writedata_out  = 32'h00000000;
    byteenable_out = FULL_WORD;
  end

  // ****************************************************************
  // one access, held until waitrequest is sampled low
  // ****************************************************************
  // word lanes from caller
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge clk_in);
    address_out    <= a;
    writedata_out  <= d;
    byteenable_out <= be;
    read_out       <= ~wr;
    write_out      <= wr;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (waitrequest_in !== 1'b0 && n < 50);
    // a stuck slave is reported instead of hanging the run
    hung = (waitrequest_in !== 1'b0);
    read_out  <= 1'b0;
    write_out <= 1'b0;
  endtask : xfer
endmodule : dbgfd_host

// >>> dv/dbgfd_top_test.sv
// self-checking bench for the debug feature discovery block
// assumes the comprehensive level with an instruction trace unit fitted
`timescale 1ns/1ns
module dbgfd_top_test;
  import dbgfd_pkg::*;
  typedef struct packed {
    logic        rd;
    logic [31:0] d;
    logic [1:0]  r;
  } dbgfd_exp_t;
  localparam logic [31:0] TE = 32'h1 << TRACE_EN_BIT;
  localparam logic [31:0] ME = 32'h1 << MON_EN_BIT;
  localparam logic [31:0] ST = 32'h1 << MON_STEP_BIT;
  localparam logic [31:0] RM = 32'h00FFFFFF << REMAP_ADDR_LSB;
  logic        clk, rst, rd, wr, waitreq, pin, ev, halted, wmatch;
  logic        halt_rq, mon, hf, step, cmatch, sv;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, sd, rnd;
  logic [3:0]  be;
  logic [1:0]  resp;
  logic [2:0]  sp;
  logic [34:0] sq[$];
  logic [34:0] s;
  dbgfd_exp_t  q[$];
  dbgfd_exp_t  e;
  int          mismatches, checked, mon_n, hf_n, stim_n;
  logic [31:0] rom_exp [8] = '{ROM_SYS_ENTRY, ROM_WATCH_BASE | 32'h1,
    ROM_BKPT_BASE | 32'h1, ROM_STIM_BASE | 32'h1, ROM_PORT_BASE,
    ROM_ITRACE_BASE | 32'h1, ROM_END_ENTRY, ROM_END_ENTRY};

  dbgfd_top #(.DEBUG_LEVEL(LVL_COMPREHENSIVE), .DAP_KIND(DAP_JTAG),
              .ITRACE_PRESENT(1'b1)) u_dut (
    .REF_CLK_IN(clk), .RESET_IN(rst), .AVS_ADDRESS_IN(addr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
    .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata),
    .AVS_WAITREQUEST_OUT(waitreq), .AVS_RESPONSE_OUT(resp),
    .EXT_DEBUG_REQUEST_IN(pin), .DEBUG_EVENT_IN(ev),
    .CORE_HALTED_IN(halted), .WATCH_MATCH_IN(wmatch),
    .HALT_REQUEST_OUT(halt_rq), .MON_EXCEPTION_OUT(mon),
    .HARD_FAULT_OUT(hf), .MON_STEP_OUT(step),
    .COMPARATOR_MATCH_OUT(cmatch), .STIM_VALID_OUT(sv),
    .STIM_PORT_OUT(sp), .STIM_DATA_OUT(sd));
  dbgfd_host u_host (.clk_in(clk), .waitrequest_in(waitreq),
    .address_out(addr), .read_out(rd), .write_out(wr),
    .writedata_out(wdata), .byteenable_out(be));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************************************
  // comparison, closing and access tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic acc(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] b, input logic [31:0] ed,
    input logic [1:0] er);
    q.push_back('{~w, ed, er});
    u_host.xfer(w, a, d, b);
    if (u_host.hung) begin
      mismatches++;
      wrap_up();
    end
  endtask : acc

  // event at cycle n must give its pulse in cycle n+1 and only then
  task automatic fire(input logic em, input logic eh);
    int m0;
    int h0;
    m0 = mon_n;
    h0 = hf_n;
    @(posedge clk);
    ev <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
    #1;
    chk("monitor pulse", {31'h0, mon}, {31'h0, em});
    chk("fault pulse", {31'h0, hf}, {31'h0, eh});
    repeat (3) @(posedge clk);
    chk("monitor count", 32'(mon_n - m0), {31'h0, em});
    chk("fault count", 32'(hf_n - h0), {31'h0, eh});
  endtask : fire

  always @(posedge clk) begin
    if ((rd || wr) && waitreq === 1'b0 && q.size() > 0) begin
      e = q.pop_front();
      if (e.rd) chk("read data", rdata, e.d);
      chk("response", {30'h0, resp}, {30'h0, e.r});
    end
    if (mon === 1'b1) mon_n++;
    if (hf === 1'b1) hf_n++;
    if (sv === 1'b1) begin
      stim_n++;
      if (sq.size() > 0) begin
        s = sq.pop_front();
        chk("stim port", {29'h0, sp}, {29'h0, s[34:32]});
        chk("stim data", sd, s[31:0]);
      end
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {rst, pin, ev, halted, wmatch} = 5'b10000;
    {mismatches, checked, mon_n, hf_n, stim_n} = '0;
    rnd = 32'h61c10bc5;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++)
      acc(1'b0, 12'(4 * i), 0, FULL_WORD, rom_exp[i], RESP_OKAY);
    acc(1'b0, LEVEL_OFS, 0, FULL_WORD, 32'h2, RESP_OKAY);
    acc(1'b0, 12'h300, 0, FULL_WORD, 32'h0, RESP_SLVERR);
    $display("table and map done");
    acc(1'b0, WATCH_CTRL_OFS, 0, FULL_WORD, 32'h0, RESP_OKAY);
    acc(1'b1, EXC_MON_OFS, TE, 4'h3, 32'h0, RESP_OKAY);
    acc(1'b0, EXC_MON_OFS, 0, FULL_WORD, 32'h0, RESP_OKAY);
    acc(1'b1, EXC_MON_OFS, TE, FULL_WORD, 32'h0, RESP_OKAY);
    acc(1'b0, EXC_MON_OFS, 0, FULL_WORD, TE, RESP_OKAY);
    acc(1'b0, WATCH_CTRL_OFS, 0, FULL_WORD, 32'h1 << NUMCMP_LSB,
        RESP_OKAY);
    acc(1'b0, BKPT_CTRL_OFS, 0, FULL_WORD, 32'h2 << NUM_CODE_LSB,
        RESP_OKAY);
    halted <= 1'b1; // core halted, read back later as the halted status bit
    rnd = lfsr(rnd);
    acc(1'b1, BKPT_REMAP_OFS, rnd, FULL_WORD, 32'h0, RESP_OKAY);
    acc(1'b0, BKPT_REMAP_OFS, 0, FULL_WORD, (32'h1 << REMAP_SUP_BIT) |
        (rnd & RM), RESP_OKAY);
    $display("capability registers done");
    for (int k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      sq.push_back({3'(k), rnd});
      acc(1'b1, STIM_BASE_OFS + 12'(4 * k), rnd, FULL_WORD, 32'h0,
          RESP_OKAY);
    end
    repeat (3) @(posedge clk);
    chk("stim pulses", 32'(stim_n), 32'h8);
    acc(1'b1, EXC_MON_OFS, 32'h0, FULL_WORD, 32'h0, RESP_OKAY);
    acc(1'b1, STIM_LAST_OFS, rnd, FULL_WORD, 32'h0, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("stim pulses off", 32'(stim_n), 32'h8);
    wmatch <= 1'b1;
    #1 chk("match high", {31'h0, cmatch}, 32'h1);
    @(posedge clk);
    wmatch <= 1'b0;
    #1 chk("match low", {31'h0, cmatch}, 32'h0);
    $display("stimulus and match done");
    acc(1'b1, EXC_MON_OFS, ME | ST, FULL_WORD, 32'h0, RESP_OKAY);
    #1 chk("step", {31'h0, step}, 32'h1);
    fire(1'b1, 1'b0);
    @(posedge clk);
    pin <= 1'b1;
    for (int n = 0; n < 10 && mon_n == 1; n++) @(posedge clk);
    chk("pin monitor entry", 32'(mon_n), 32'h2);
    pin <= 1'b0;
    acc(1'b1, EXC_MON_OFS, 32'h0, FULL_WORD, 32'h0, RESP_OKAY);
    fire(1'b0, 1'b1);
    acc(1'b1, EXC_MON_OFS, ME, FULL_WORD, 32'h0, RESP_OKAY);
    acc(1'b1, HALT_CTRL_OFS, 32'h1, FULL_WORD, 32'h0, RESP_OKAY);
    fire(1'b0, 1'b0);
    chk("halt request", {31'h0, halt_rq}, 32'h1);
    acc(1'b0, HALT_CTRL_OFS, 0, FULL_WORD, (32'h1 << HALTED_BIT) | 32'h3,
        RESP_OKAY);
    $display("events and halting done");
    repeat (2) @(posedge clk);
    wrap_up();
  end
endmodule : dbgfd_top_test
